//--- common/tna_defines.svh
`ifndef TNA_DEFINES_SVH
`define TNA_DEFINES_SVH
// ----------------------------------------
// Phit layout
// ----------------------------------------
`define TNA_WORD_W 32
`define TNA_HALF_W 16
// ----------------------------------------
// Table sizes
// ----------------------------------------
`define TNA_SLOTS 8
`define TNA_SLOT_AW 3
`define TNA_DMAS 4
`define TNA_DMA_AW 2
// ----------------------------------------
// Register map, word addresses
// ----------------------------------------
`define TNA_ADDR_W 8
`define TNA_REG_SLOT 4'h0
`define TNA_REG_DMA 4'h1
`define TNA_REG_STAT 8'h20
`define TNA_FLD_CTRL 2'h0
`define TNA_FLD_ROUTE 2'h1
`define TNA_FLD_PTR 2'h2
`define TNA_FLD_CNT 2'h3
// ----------------------------------------
// Phase delays and pointer steps
// ----------------------------------------
`define TNA_PH_0 2'h0
`define TNA_PH_1 2'h1
`define TNA_PKT_WORDS 16'h0002
`define TNA_ONE 16'h0001
`define TNA_SLOT_ONE 3'h1
`endif

//--- common/tna_pkg.sv
`include "tna_defines.svh"
package tna_pkg;
  typedef struct packed {
    logic vld;
    logic sop;
    logic eop;
    logic [`TNA_WORD_W-1:0] data;
  } tna_phit_t;
  typedef struct packed {
    logic vld;
    logic [1:0] phase;
    logic [`TNA_DMA_AW-1:0] idx;
  } tna_slot_t;
  typedef struct packed {
    logic en;
    logic [`TNA_HALF_W-1:0] route;
    logic [`TNA_HALF_W-1:0] rp;
    logic [`TNA_HALF_W-1:0] wp;
    logic [`TNA_HALF_W-1:0] cnt;
  } tna_dma_t;
  typedef enum logic [1:0] {POS_HDR = 2'b00, POS_W0 = 2'b01, POS_W1 = 2'b11} tna_pos_t;
  typedef enum logic [1:0] {WR_IDLE = 2'b00, WR_W0 = 2'b01, WR_W1 = 2'b11} tna_wr_t;
  typedef struct packed {
    tna_slot_t [`TNA_SLOTS-1:0] slot;
    tna_dma_t [`TNA_DMAS-1:0] dma;
    logic [`TNA_SLOT_AW-1:0] slot_no;
    tna_pos_t pos;
    logic snd;
    logic [1:0] phase;
    logic [`TNA_HALF_W-1:0] raddr;
    tna_phit_t out;
    tna_phit_t dl1;
    tna_phit_t dl2;
    tna_phit_t tx;
    logic tgl;
    tna_phit_t s1;
    tna_phit_t s2;
    logic [`TNA_HALF_W-1:0] rwp;
    logic [`TNA_WORD_W-1:0] rd0;
    logic [`TNA_HALF_W-1:0] bwp;
    logic [`TNA_WORD_W-1:0] bd0;
    logic [`TNA_WORD_W-1:0] bd1;
    tna_wr_t wr;
    logic we;
    logic [`TNA_HALF_W-1:0] waddr;
    logic [`TNA_WORD_W-1:0] wdata;
    logic [`TNA_WORD_W-1:0] rdata;
  } tna_state_t;
endpackage

//--- hdl/tna_adapter.sv
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "tna_defines.svh"
// Overview of operation
// - A packet is one header phit then two payload phits of one word each.
// - Header carries 16-bit route and 16-bit target write pointer from DMA entry.
// - Each phit is the 32-bit word plus valid, start and end bits.
// - Data is valid before a request toggle and held until acknowledge.
// - Clock halved by a toggle serves as handshake on both channels.
// - Toggle drives outgoing request; router acknowledge is ignored.
// - Outgoing request reaches router only after the registered phit settles.
// - Toggle drives incoming acknowledge; router must finish handshakes faster.
// - Every clock one phit goes out and one phit comes in.
// - Idle slots send all-zero void phits; invalid incoming phits are void.
// - After reset no valid phits leave until software configures tables.
// - Slot counter advances every third clock, after the last phit, in step with all adapters.
// - Slot table entry holds valid bit and DMA table index.
// - DMA entry holds control, read pointer, write pointer, count, route.
// - Processor configures and reads back DMA entries over the register port.
// - Scratch memory read and write ports plus phit-wide network ports.
// - Slot entry has 2-bit phase field for 0, 1 or 2 cycle delay.
// - Two single-phit delay stages; output mux picks delay by phase.
// - Last phit's address and data are buffered; memory write follows packet.
module tna_adapter (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [`TNA_ADDR_W-1:0] I_ADDR,
  input wire logic [`TNA_WORD_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [`TNA_WORD_W-1:0] O_RDATA,
  output logic [`TNA_HALF_W-1:0] O_SPM_RADDR,
  input wire logic [`TNA_WORD_W-1:0] I_SPM_RDATA,
  output logic O_SPM_WE,
  output logic [`TNA_HALF_W-1:0] O_SPM_WADDR,
  output logic [`TNA_WORD_W-1:0] O_SPM_WDATA,
  output tna_pkg::tna_phit_t O_TX_PHIT,
  output logic O_TX_REQ,
  input wire logic I_TX_ACK,
  input wire tna_pkg::tna_phit_t I_RX_PHIT,
  input wire logic I_RX_REQ,
  output logic O_RX_ACK
);

  tna_pkg::tna_state_t st_q;
  tna_pkg::tna_state_t st_d;
  tna_pkg::tna_slot_t ent;
  tna_pkg::tna_dma_t dsel;
  tna_pkg::tna_dma_t dwr;
  logic go;
  logic [`TNA_DMA_AW-1:0] bidx;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // The whole adapter is one state record; this process computes its successor
  always_comb
  begin
    st_d = st_q;
    ent = st_q.slot[st_q.slot_no];
    dsel = st_q.dma[ent.idx];
    go = 1'b0;
    bidx = I_ADDR[3:2];
    dwr = st_q.dma[bidx];
    st_d.we = 1'b0;
    st_d.rdata = '0;
    // Halved clock for both handshakes; one toggle per phit
    st_d.tgl = ~st_q.tgl;

    // Phit position steps on every clock edge; slot counter steps after the last phit
    unique case (st_q.pos)
      tna_pkg::POS_HDR:
      begin
        st_d.pos = tna_pkg::POS_W0;
        // Slot table picks the DMA entry; an empty count stops sending
        go = ent.vld && dsel.en && (dsel.cnt != '0);
        st_d.snd = go;
        st_d.out = '0;
        if (go)
        begin
          st_d.out.vld = 1'b1;
          st_d.out.sop = 1'b1;
          st_d.out.data = {dsel.route, dsel.wp};
          st_d.phase = ent.phase;
          st_d.raddr = dsel.rp;
          // Pointers step by the two words this packet carries
          st_d.dma[ent.idx].rp = dsel.rp + `TNA_PKT_WORDS;
          st_d.dma[ent.idx].wp = dsel.wp + `TNA_PKT_WORDS;
          if (dsel.cnt > `TNA_PKT_WORDS)
          begin
            st_d.dma[ent.idx].cnt = dsel.cnt - `TNA_PKT_WORDS;
          end
          else
          begin
            st_d.dma[ent.idx].cnt = '0;
          end
        end
      end
      tna_pkg::POS_W0:
      begin
        st_d.pos = tna_pkg::POS_W1;
        st_d.out = '0;
        if (st_q.snd)
        begin
          st_d.out.vld = 1'b1;
          st_d.out.data = I_SPM_RDATA;
          st_d.raddr = st_q.raddr + `TNA_ONE;
        end
      end
      tna_pkg::POS_W1:
      begin
        st_d.pos = tna_pkg::POS_HDR;
        st_d.slot_no = st_q.slot_no + `TNA_SLOT_ONE;
        st_d.out = '0;
        if (st_q.snd)
        begin
          st_d.out.vld = 1'b1;
          st_d.out.eop = 1'b1;
          st_d.out.data = I_SPM_RDATA;
        end
      end
    endcase

    // Two single-phit delay stages; phase is only taken when a packet is sent,
    // so the tail of a delayed packet is not cut off by an idle slot
    st_d.dl1 = st_q.out;
    st_d.dl2 = st_q.dl1;
    unique case (st_q.phase)
      `TNA_PH_0: st_d.tx = st_q.out;
      `TNA_PH_1: st_d.tx = st_q.dl1;
      default: st_d.tx = st_q.dl2;
    endcase

    // Incoming phit is sampled twice since it comes from the self-timed side
    st_d.s1 = I_RX_PHIT;
    st_d.s2 = st_q.s1;

    // Assemble arriving packet; invalid phits are skipped as void
    if (st_q.s2.vld)
    begin
      if (st_q.s2.sop)
      begin
        st_d.rwp = st_q.s2.data[`TNA_HALF_W-1:0];
      end
      else if (!st_q.s2.eop)
      begin
        st_d.rd0 = st_q.s2.data;
      end
      else
      begin
        // Last phit: hold address and both words, write afterwards
        st_d.bwp = st_q.rwp;
        st_d.bd0 = st_q.rd0;
        st_d.bd1 = st_q.s2.data;
        st_d.wr = tna_pkg::WR_W0;
      end
    end

    // Deferred scratch memory write, two words back to back
    unique case (st_q.wr)
      tna_pkg::WR_IDLE:
      begin
      end
      tna_pkg::WR_W0:
      begin
        st_d.we = 1'b1;
        st_d.waddr = st_q.bwp;
        st_d.wdata = st_q.bd0;
        if (!(st_q.s2.vld && st_q.s2.eop))
        begin
          st_d.wr = tna_pkg::WR_W1;
        end
      end
      tna_pkg::WR_W1:
      begin
        st_d.we = 1'b1;
        st_d.waddr = st_q.bwp + `TNA_ONE;
        st_d.wdata = st_q.bd1;
        if (!(st_q.s2.vld && st_q.s2.eop))
        begin
          st_d.wr = tna_pkg::WR_IDLE;
        end
      end
      default:
      begin
        st_d.wr = tna_pkg::WR_IDLE;
      end
    endcase

    // Register reads; data stands in the cycle after the strobe
    if (I_RD)
    begin
      if (I_ADDR[7:4] == `TNA_REG_SLOT && !I_ADDR[3])
      begin
        st_d.rdata = {27'h0000000, st_q.slot[I_ADDR[2:0]]};
      end
      else if (I_ADDR[7:4] == `TNA_REG_DMA)
      begin
        unique case (I_ADDR[1:0])
          `TNA_FLD_CTRL: st_d.rdata = {31'h00000000, dwr.en};
          `TNA_FLD_ROUTE: st_d.rdata = {16'h0000, dwr.route};
          `TNA_FLD_PTR: st_d.rdata = {dwr.rp, dwr.wp};
          `TNA_FLD_CNT: st_d.rdata = {16'h0000, dwr.cnt};
        endcase
      end
      else if (I_ADDR == `TNA_REG_STAT)
      begin
        st_d.rdata = {27'h0000000, st_q.slot_no, st_q.pos};
      end
    end

    // Register writes; software wins over the pointer update of the same cycle
    if (I_WR)
    begin
      if (I_ADDR[7:4] == `TNA_REG_SLOT && !I_ADDR[3])
      begin
        st_d.slot[I_ADDR[2:0]] = I_WDATA[4:0];
      end
      else if (I_ADDR[7:4] == `TNA_REG_DMA)
      begin
        unique case (I_ADDR[1:0])
          `TNA_FLD_CTRL: st_d.dma[bidx].en = I_WDATA[0];
          `TNA_FLD_ROUTE: st_d.dma[bidx].route = I_WDATA[15:0];
          `TNA_FLD_PTR:
          begin
            st_d.dma[bidx].rp = I_WDATA[31:16];
            st_d.dma[bidx].wp = I_WDATA[15:0];
          end
          `TNA_FLD_CNT: st_d.dma[bidx].cnt = I_WDATA[15:0];
        endcase
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset clears both tables, so nothing valid leaves until configured
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Request and phit change on the same edge; the link delay element holds
  // the request back until the phit has settled at the router.
  // The router acknowledge and request are unused by design.
  assign O_TX_PHIT = st_q.tx;
  assign O_TX_REQ = st_q.tgl;
  assign O_RX_ACK = st_q.tgl;
  assign O_SPM_RADDR = st_q.raddr;
  assign O_SPM_WE = st_q.we;
  assign O_SPM_WADDR = st_q.waddr;
  assign O_SPM_WDATA = st_q.wdata;
  assign O_RDATA = st_q.rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Helper: remembers whether software has written anything since reset
  logic cfg_q;
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      cfg_q <= 1'b0;
    end
    else if (I_WR)
    begin
      cfg_q <= 1'b1;
    end
  end

  property p_void;
    @(posedge I_CLK) disable iff (!I_RST_B)
    !O_TX_PHIT.vld |-> (O_TX_PHIT == '0);
  endproperty
  a_void: assert property (p_void) else $error("void phit not all zero");

  // The edge that releases reset and the one after it still see the cleared toggle
  property p_toggle;
    @(posedge I_CLK) disable iff (!I_RST_B)
    I_RST_B && $past(I_RST_B) |-> (O_TX_REQ != $past(O_TX_REQ)) && (O_RX_ACK == O_TX_REQ);
  endproperty
  a_toggle: assert property (p_toggle) else $error("handshake did not toggle");

  property p_quiet;
    @(posedge I_CLK) disable iff (!I_RST_B)
    !cfg_q |-> !O_TX_PHIT.vld && !st_q.out.vld;
  endproperty
  a_quiet: assert property (p_quiet) else $error("valid phit before configuration");

  property p_pkt;
    @(posedge I_CLK) disable iff (!I_RST_B)
    st_q.out.sop |-> !st_q.out.eop ##1 (st_q.out.vld && !st_q.out.sop && !st_q.out.eop)
      ##1 (st_q.out.vld && !st_q.out.sop && st_q.out.eop);
  endproperty
  a_pkt: assert property (p_pkt) else $error("packet framing wrong");

  property p_hdr;
    @(posedge I_CLK) disable iff (!I_RST_B)
    $rose(st_q.out.sop) |-> st_q.out.data[`TNA_HALF_W-1:0] == $past(dsel.wp)
      && st_q.out.data[`TNA_WORD_W-1:`TNA_HALF_W] == $past(dsel.route);
  endproperty
  a_hdr: assert property (p_hdr) else $error("header fields wrong");

  property p_step;
    @(posedge I_CLK) disable iff (!I_RST_B)
    go && !I_WR |=> st_q.dma[$past(ent.idx)].rp == $past(dsel.rp) + `TNA_PKT_WORDS
      && st_q.dma[$past(ent.idx)].cnt < $past(dsel.cnt);
  endproperty
  a_step: assert property (p_step) else $error("DMA entry did not advance");

  property p_delay;
    @(posedge I_CLK) disable iff (!I_RST_B)
    ##2 ($past(st_q.phase) == `TNA_PH_1) |-> O_TX_PHIT == $past(st_q.out, 2);
  endproperty
  a_delay: assert property (p_delay) else $error("one cycle phase delay wrong");

  property p_slot;
    @(posedge I_CLK) disable iff (!I_RST_B)
    st_q.pos == tna_pkg::POS_W1 |=> st_q.pos == tna_pkg::POS_HDR
      && st_q.slot_no == $past(st_q.slot_no) + `TNA_SLOT_ONE;
  endproperty
  a_slot: assert property (p_slot) else $error("slot counter did not advance");

  property p_rxwr;
    @(posedge I_CLK) disable iff (!I_RST_B)
    st_q.s2.vld && st_q.s2.eop |-> ##2 O_SPM_WE ##1 O_SPM_WE;
  endproperty
  a_rxwr: assert property (p_rxwr) else $error("deferred write missing");

  // Void incoming phits must not disturb a packet being assembled
  property p_rxhold;
    @(posedge I_CLK) disable iff (!I_RST_B)
    !st_q.s2.vld |=> st_q.rwp == $past(st_q.rwp) && st_q.rd0 == $past(st_q.rd0)
      && st_q.wr != tna_pkg::WR_W0;
  endproperty
  a_rxhold: assert property (p_rxhold) else $error("void phit changed receive state");

  // Second payload word lands one address above the first, in the next cycle
  property p_wpair;
    @(posedge I_CLK) disable iff (!I_RST_B)
    $rose(O_SPM_WE) |=> O_SPM_WE && O_SPM_WADDR == $past(O_SPM_WADDR) + `TNA_ONE;
  endproperty
  a_wpair: assert property (p_wpair) else $error("second payload write misplaced");

  // Read data stands only after a read strobe, so stale words never leak out
  property p_rdclr;
    @(posedge I_CLK) disable iff (!I_RST_B)
    !$past(I_RD) |-> O_RDATA == '0;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("read data outside read cycle");

  // Incoming phit reaches the assembly exactly two edges after the pin
  property p_sync;
    @(posedge I_CLK) disable iff (!I_RST_B)
    I_RST_B && $past(I_RST_B) && $past(I_RST_B, 2) |-> st_q.s2 == $past(I_RX_PHIT, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("incoming phit not two stages late");

  // Outside a scheduled packet the staged phit is a void one
  property p_idle;
    @(posedge I_CLK) disable iff (!I_RST_B)
    !st_q.snd |-> st_q.out == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("valid phit outside a packet");

endmodule

//--- bench/tna_router_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Router end of both links
// ----------------------------------------
// Loops every outgoing phit back in as incoming traffic, so one sent
// packet also exercises the receive path and the scratch writes.
module tna_router_model (
  input wire logic i_req,
  input wire tna_pkg::tna_phit_t i_phit,
  output logic o_ack,
  output tna_pkg::tna_phit_t o_phit,
  output logic o_req
);
  // Quiet links after power-up: routers start out holding void phits
  initial
  begin
    o_ack = 1'b0;
    o_req = 1'b0;
    o_phit = '0;
  end
  // Each request toggle is one handshake; sample only after the link delay
  always @(i_req)
  begin
    #5;
    o_phit = i_phit;
    o_req = ~o_req;
    o_ack = i_req;
  end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/100ps
`include "tna_defines.svh"
module tb_top;
  typedef struct {logic [1:0] ph; logic [15:0] rp; logic [15:0] wp; logic [15:0] rt;} tna_row_t;
  logic clk, rst_b, wr_s, rd_s, spm_we, tx_req, tx_ack, rx_req, rx_ack, t;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, spm_rdata, spm_wdata, rv;
  logic [15:0] spm_raddr, spm_waddr, cur_rp;
  tna_pkg::tna_phit_t tx_phit, rx_phit;
  tna_pkg::tna_phit_t seen [0:2];
  logic [31:0] mem [0:255];
  logic [31:0] wmem [0:255];
  int miscompares = 0, tests_run = 0, cyc = 0, ra_cyc = -1, tx_cyc = 0;
  int n_sop = 0, n_vld = 0, void_bad = 0, j;
  tna_row_t rows [0:2] = '{'{2'h0, 16'h0010, 16'h0080, 16'h1234},
    '{2'h1, 16'h0020, 16'h0090, 16'hABCD}, '{2'h2, 16'h0030, 16'h00A0, 16'h5A0F}};
  // ----------------------------------------
  // Device, router and scratch memory
  // ----------------------------------------
  tna_adapter u_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .O_SPM_RADDR(spm_raddr),
    .I_SPM_RDATA(spm_rdata), .O_SPM_WE(spm_we), .O_SPM_WADDR(spm_waddr),
    .O_SPM_WDATA(spm_wdata), .O_TX_PHIT(tx_phit), .O_TX_REQ(tx_req), .I_TX_ACK(tx_ack),
    .I_RX_PHIT(rx_phit), .I_RX_REQ(rx_req), .O_RX_ACK(rx_ack));
  tna_router_model u_rtr (.i_req(tx_req), .i_phit(tx_phit), .o_ack(tx_ack),
    .o_phit(rx_phit), .o_req(rx_req));
  // Memory answers in the same cycle as the address
  assign spm_rdata = mem[spm_raddr[7:0]];
  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watch the outgoing link and record scratch writes
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (spm_raddr === cur_rp && tx_cyc < 0) ra_cyc <= cyc;
    if (tx_phit.vld === 1'b1) n_vld <= n_vld + 1;
    if (tx_phit.sop === 1'b1) n_sop <= n_sop + 1;
    if (tx_phit.vld !== 1'b1 && tx_phit !== '0) void_bad <= void_bad + 1;
    if (tx_cyc < 0 && tx_phit.vld === 1'b1)
    begin
      tx_cyc <= cyc;
      seen[0] <= tx_phit;
    end
    else if (tx_cyc >= 0 && cyc - tx_cyc < 3) seen[cyc - tx_cyc] <= tx_phit;
    if (spm_we === 1'b1) wmem[spm_waddr[7:0]] <= spm_wdata;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_b = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    cur_rp = 16'hFFFF;
    for (j = 0; j < 256; j++) mem[j] = {24'hC0FFEE, 8'(j)};
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (30) @(posedge clk);
    chk("idle vld", n_vld, 0);
    #1 t = tx_req;
    @(posedge clk);
    #1 chk("req toggle", tx_req, !t);
    chk("rx ack", rx_ack, tx_req);
    reg_rd(8'h30, rv);
    chk("unmapped", rv, 0);
    // One packet per row, each with its own phase delay
    foreach (rows[i])
    begin
      reg_wr(8'h10, 32'h00000000);
      reg_wr(8'h11, {16'h0000, rows[i].rt});
      reg_wr(8'h12, {rows[i].rp, rows[i].wp});
      reg_wr(8'h13, 32'h00000002);
      reg_wr(8'h00, {27'h0, 1'b1, rows[i].ph, 2'b00});
      #1;
      cur_rp = rows[i].rp;
      tx_cyc = -1;
      n_sop = 0;
      reg_wr(8'h10, 32'h00000001);
      for (j = 0; j < 200 && tx_cyc < 0; j++) @(posedge clk);
      if (tx_cyc < 0)
      begin
        miscompares++;
        wrap_up;
      end
      repeat (40) @(posedge clk);
      chk("sop count", n_sop, 1);
      chk("hdr", seen[0], {3'b110, rows[i].rt, rows[i].wp});
      chk("w0", seen[1], {3'b100, mem[rows[i].rp]});
      chk("w1", seen[2], {3'b101, mem[rows[i].rp + 1]});
      chk("phase", tx_cyc - ra_cyc, 1 + rows[i].ph);
      chk("spm w0", wmem[rows[i].wp], mem[rows[i].rp]);
      chk("spm w1", wmem[rows[i].wp + 1], mem[rows[i].rp + 1]);
      reg_rd(8'h12, rv);
      chk("ptr", rv, {rows[i].rp + `TNA_PKT_WORDS, rows[i].wp + `TNA_PKT_WORDS});
      reg_rd(8'h13, rv);
      chk("cnt", rv, 0);
      reg_rd(8'h10, rv);
      chk("ctrl", rv, 1);
    end
    chk("void", void_bad, 0);
    // Reset in mid-run clears the tables and silences the link
    @(negedge clk);
    rst_b = 1'b0;
    #1 chk("rst phit", tx_phit, 0);
    chk("rst req", tx_req, 0);
    chk("rst we", spm_we, 0);
    @(posedge clk);
    rst_b <= 1'b1;
    #1 n_vld = 0;
    reg_rd(8'h00, rv);
    chk("slot clr", rv, 0);
    reg_rd(8'h10, rv);
    chk("ctrl clr", rv, 0);
    repeat (30) @(posedge clk);
    chk("post rst vld", n_vld, 0);
    wrap_up;
  end
endmodule
